//--- hw/jtg_pkg.sv
package jtg_pkg;

  // Scan register widths
  localparam int IR_W   = 8;
  localparam int ID_W   = 32;
  localparam int BSR_W  = 135;
  localparam int MR01_W = 12;
  localparam int MTWO_W = 10;

  // Instruction codes
  localparam logic [IR_W-1:0] INS_EXTEST    = 8'h00;
  localparam logic [IR_W-1:0] INS_IDCODE    = 8'h21;
  localparam logic [IR_W-1:0] INS_SAMPLE    = 8'h05;
  localparam logic [IR_W-1:0] INS_CLAMP     = 8'h07;
  localparam logic [IR_W-1:0] INS_HIGHZ     = 8'h03;
  localparam logic [IR_W-1:0] INS_MODE_PAIR = 8'h25;
  localparam logic [IR_W-1:0] INS_MODE_TWO  = 8'h29;
  localparam logic [IR_W-1:0] INS_BYPASS    = 8'hFF;

  // Fixed pattern in the low instruction bits at capture
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;

  // Field positions inside the identification word
  localparam int ID_PRESENT_BIT = 0;
  localparam int ID_MZERO_LSB   = 1;
  localparam int ID_REPAIR_BIT  = 13;
  localparam int ID_MONE_LSB    = 17;
  localparam int ID_MTWO_LSB    = 1;

  // Reset values
  localparam logic [ID_W-1:0] ID_CODE_DEFAULT = 32'h1A5C_3E17; // Arbitrary value
  localparam logic            BYPASS_CAPTURE  = 1'h0;

  // Standard sixteen-state test access controller
  typedef enum {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } jtg_state_t;

endpackage : jtg_pkg

//--- hw/jtg_tap_fsm.sv
`timescale 1ns/10ps
module jtg_tap_fsm
  import jtg_pkg::*;
(
  // Test clock domain
  input  wire logic tck,
  input  wire logic tck_rst_n,
  // Mode select
  input  wire logic tms,
  // Controller state
  output jtg_state_t state_r
);

  jtg_state_t state_nxt;

  // State walk steered by the mode select line
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_TLR:    state_nxt = tms ? ST_TLR    : ST_RTI;
      ST_RTI:    state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_nxt = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_nxt = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_nxt = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_nxt = tms ? ST_SEL_DR : ST_RTI;
      default:   state_nxt = ST_TLR;
    endcase
  end

  // State register; reset parks the controller in test-logic-reset
  always_ff @(posedge tck)
  begin
    if (!tck_rst_n)
      state_r <= ST_TLR;
    else
      state_r <= state_nxt;
  end

  // Five high mode-select edges reach test-logic-reset from anywhere
  tlr_five_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    tms [*5] |=> state_r == ST_TLR)
    else $error("five high tms edges did not reach reset state");

endmodule : jtg_tap_fsm

//--- hw/jtg_tap_top.sv
`timescale 1ns/10ps
// Overview of operation
// - 32-bit ID register loads identity or mode words at capture-DR.
// - ID register shifts captured contents out during shift-DR.
// - Instruction register is 8 bits; only listed codes are implemented.
// - Instructions shift in during shift-IR, take effect at update-IR.
// - External test drives outputs from cells, inputs get captured.
// - Update-IR with external test enables drivers with preloaded values.
// - Identification instruction loads fixed 32-bit code, selects ID register.
// - Instruction register holds identification after power-up and reset state.
// - Mode-pair readout loads mode registers zero and one into ID.
// - Mode-two readout loads mode register two into ID register.
// - High-impedance instruction selects bypass and floats every output.
// - Clamp drives every output ball from its boundary cell.
// - Sample/preload snapshots pins at capture-DR without disturbing operation.
// - After sampling, shift-DR puts boundary register on the scan path.
// - Bypass instruction makes the single bypass bit the scan path.
// - Decode external test 00, identification 21, sample/preload 05 (hex).
// - Decode clamp 07, high-Z 03, bypass FF, mode pair 25, two 29.
// - Mode-two word: register bits 9..0 at 10..1, bit 0 one.
// - Capture-IR loads 01 into the two low instruction bits.
module jtg_tap_top
  import jtg_pkg::*;
#(
  parameter logic [ID_W-1:0] ID_CODE = ID_CODE_DEFAULT
)
(
  // System clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Mode register contents, system clock domain
  input  wire logic [MR01_W-1:0]  mode_register_zero,
  input  wire logic [MR01_W-1:0]  mode_register_one,
  input  wire logic [MTWO_W-1:0]  mode_register_two,
  input  wire logic               post_package_repair_flag,
  // Test access port, test clock domain
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  // Boundary cells at the balls
  input  wire logic [BSR_W-1:0]   pin_in,
  output logic [BSR_W-1:0]        pin_drive,
  output logic                    pin_test_en,
  output logic                    pin_hiz
);

  // Reset and pin synchronisers in the test clock domain
  logic               trst_s1_r;
  logic               trst_s2_r;
  logic [BSR_W-1:0]   pin_s1_r;
  logic [BSR_W-1:0]   pin_s2_r;

  // Word handshake, system side
  logic               req_s1_r;
  logic               req_s2_r;
  logic               ack_tgl_r;
  logic               ack_tgl_nxt;
  logic [MR01_W-1:0]  mzero_hold_r;
  logic [MR01_W-1:0]  mzero_hold_nxt;
  logic [MR01_W-1:0]  mone_hold_r;
  logic [MR01_W-1:0]  mone_hold_nxt;
  logic [MTWO_W-1:0]  mtwo_hold_r;
  logic [MTWO_W-1:0]  mtwo_hold_nxt;
  logic               rep_hold_r;
  logic               rep_hold_nxt;

  // Word handshake, test clock side
  logic               ack_s1_r;
  logic               ack_s2_r;
  logic               req_tgl_r;
  logic               req_tgl_nxt;
  logic [MR01_W-1:0]  mzero_c_r;
  logic [MR01_W-1:0]  mzero_c_nxt;
  logic [MR01_W-1:0]  mone_c_r;
  logic [MR01_W-1:0]  mone_c_nxt;
  logic [MTWO_W-1:0]  mtwo_c_r;
  logic [MTWO_W-1:0]  mtwo_c_nxt;
  logic               rep_c_r;
  logic               rep_c_nxt;

  // Controller, instruction and data registers
  jtg_state_t         state;
  logic [IR_W-1:0]    ir_shift_r;
  logic [IR_W-1:0]    ir_shift_nxt;
  logic [IR_W-1:0]    ir_r;
  logic [IR_W-1:0]    ir_nxt;
  logic               sel_id;
  logic               sel_bsr;
  logic               sel_byp;
  logic [ID_W-1:0]    pair_word;
  logic [ID_W-1:0]    two_word;
  logic [ID_W-1:0]    id_shift_r;
  logic [ID_W-1:0]    id_shift_nxt;
  logic               bypass_r;
  logic               bypass_nxt;
  logic [BSR_W-1:0]   bsr_shift_r;
  logic [BSR_W-1:0]   bsr_shift_nxt;
  logic [BSR_W-1:0]   bsr_upd_r;
  logic [BSR_W-1:0]   bsr_upd_nxt;
  logic               pin_test_en_r;
  logic               pin_test_en_nxt;
  logic               pin_hiz_r;
  logic               pin_hiz_nxt;
  logic               tdo_r;
  logic               tdo_nxt;
  logic               tdo_oe_r;
  logic               tdo_oe_nxt;
  logic               tck_rst_n;

  // Reset and ball values carried into the test clock; capture sees settled data
  always_ff @(posedge tck)
  begin
    trst_s1_r <= rst_n;
    trst_s2_r <= trst_s1_r;
    pin_s1_r  <= pin_in;
    pin_s2_r  <= pin_s1_r;
  end

  assign tck_rst_n = trst_s2_r;

  // Request toggle carried into the system clock
  always_ff @(posedge ref_clk)
  begin
    req_s1_r <= req_tgl_r;
    req_s2_r <= req_s1_r;
  end

  // System side refreshes the hold words only while the test side is not reading
  always_comb
  begin
    ack_tgl_nxt    = ack_tgl_r;
    mzero_hold_nxt = mzero_hold_r;
    mone_hold_nxt  = mone_hold_r;
    mtwo_hold_nxt  = mtwo_hold_r;
    rep_hold_nxt   = rep_hold_r;
    if (req_s2_r != ack_tgl_r)
    begin
      mzero_hold_nxt = mode_register_zero;
      mone_hold_nxt  = mode_register_one;
      mtwo_hold_nxt  = mode_register_two;
      rep_hold_nxt   = post_package_repair_flag;
      ack_tgl_nxt    = req_s2_r;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ack_tgl_r    <= 1'h0;
      mzero_hold_r <= '0;
      mone_hold_r  <= '0;
      mtwo_hold_r  <= '0;
      rep_hold_r   <= 1'h0;
    end
    else
    begin
      ack_tgl_r    <= ack_tgl_nxt;
      mzero_hold_r <= mzero_hold_nxt;
      mone_hold_r  <= mone_hold_nxt;
      mtwo_hold_r  <= mtwo_hold_nxt;
      rep_hold_r   <= rep_hold_nxt;
    end
  end

  // Acknowledge toggle carried into the test clock
  always_ff @(posedge tck)
  begin
    ack_s1_r <= ack_tgl_r;
    ack_s2_r <= ack_s1_r;
  end

  // Test side copies hold words once acknowledged; they stay still until next request
  always_comb
  begin
    req_tgl_nxt = req_tgl_r;
    mzero_c_nxt = mzero_c_r;
    mone_c_nxt  = mone_c_r;
    mtwo_c_nxt  = mtwo_c_r;
    rep_c_nxt   = rep_c_r;
    if (ack_s2_r == req_tgl_r)
    begin
      mzero_c_nxt = mzero_hold_r;
      mone_c_nxt  = mone_hold_r;
      mtwo_c_nxt  = mtwo_hold_r;
      rep_c_nxt   = rep_hold_r;
      req_tgl_nxt = ~req_tgl_r;
    end
  end

  always_ff @(posedge tck)
  begin
    if (!tck_rst_n)
    begin
      req_tgl_r <= 1'h0;
      mzero_c_r <= '0;
      mone_c_r  <= '0;
      mtwo_c_r  <= '0;
      rep_c_r   <= 1'h0;
    end
    else
    begin
      req_tgl_r <= req_tgl_nxt;
      mzero_c_r <= mzero_c_nxt;
      mone_c_r  <= mone_c_nxt;
      mtwo_c_r  <= mtwo_c_nxt;
      rep_c_r   <= rep_c_nxt;
    end
  end

  // Controller
  jtg_tap_fsm u_fsm (
    .tck       (tck),
    .tck_rst_n (tck_rst_n),
    .tms       (tms),
    .state_r   (state)
  );

  // Decode; reserved codes fall back to bypass so the chain stays intact
  always_comb
  begin
    sel_id  = 1'h0;
    sel_bsr = 1'h0;
    case (ir_r)
      INS_IDCODE, INS_MODE_PAIR, INS_MODE_TWO: sel_id  = 1'h1;
      INS_EXTEST, INS_SAMPLE:                  sel_bsr = 1'h1;
      default:                                 sel_id  = 1'h0;
    endcase
    sel_byp = !sel_id && !sel_bsr;
  end

  // Mode readout words; undefined bits read as zero
  always_comb
  begin
    pair_word                           = '0;
    pair_word[ID_PRESENT_BIT]           = 1'h1;
    pair_word[ID_MZERO_LSB +: MR01_W]   = mzero_c_r;
    pair_word[ID_MONE_LSB +: MR01_W]    = mone_c_r;
    pair_word[ID_REPAIR_BIT]            = rep_c_r;
    two_word                            = '0;
    two_word[ID_PRESENT_BIT]            = 1'h1;
    two_word[ID_MTWO_LSB +: MTWO_W]     = mtwo_c_r;
  end

  // Instruction path; new code lands in update-IR, identification code in test-logic-reset
  always_comb
  begin
    ir_shift_nxt = ir_shift_r;
    ir_nxt       = ir_r;
    case (state)
      ST_TLR:    ir_nxt = INS_IDCODE;
      ST_CAP_IR: ir_shift_nxt = {{(IR_W-2){1'h0}}, IR_CAPTURE_PAT};
      ST_SH_IR:  ir_shift_nxt = {tdi, ir_shift_r[IR_W-1:1]};
      ST_UPD_IR: ir_nxt = ir_shift_r;
      default:   ir_nxt = ir_r;
    endcase
    // Pin control follows the instruction in the same edge it takes effect
    pin_test_en_nxt = (ir_nxt == INS_EXTEST) || (ir_nxt == INS_CLAMP);
    pin_hiz_nxt     = (ir_nxt == INS_HIGHZ);
  end

  always_ff @(posedge tck)
  begin
    if (!tck_rst_n)
    begin
      ir_shift_r    <= INS_IDCODE;
      ir_r          <= INS_IDCODE;
      pin_test_en_r <= 1'h0;
      pin_hiz_r     <= 1'h0;
    end
    else
    begin
      ir_shift_r    <= ir_shift_nxt;
      ir_r          <= ir_nxt;
      pin_test_en_r <= pin_test_en_nxt;
      pin_hiz_r     <= pin_hiz_nxt;
    end
  end

  // Data registers: capture, shift toward the low bit, update
  always_comb
  begin
    id_shift_nxt  = id_shift_r;
    bypass_nxt    = bypass_r;
    bsr_shift_nxt = bsr_shift_r;
    bsr_upd_nxt   = bsr_upd_r;
    case (state)
      ST_CAP_DR:
      begin
        if (sel_id)
        begin
          case (ir_r)
            INS_MODE_PAIR: id_shift_nxt = pair_word;
            INS_MODE_TWO:  id_shift_nxt = two_word;
            default:       id_shift_nxt = ID_CODE;
          endcase
        end
        if (sel_byp)
          bypass_nxt = BYPASS_CAPTURE;
        if (sel_bsr)
          bsr_shift_nxt = pin_s2_r;
      end
      ST_SH_DR:
      begin
        if (sel_id)
          id_shift_nxt = {tdi, id_shift_r[ID_W-1:1]};
        if (sel_byp)
          bypass_nxt = tdi;
        if (sel_bsr)
          bsr_shift_nxt = {tdi, bsr_shift_r[BSR_W-1:1]};
      end
      // Drive latch moves only here, so sampling never disturbs the balls
      ST_UPD_DR:
      begin
        if (sel_bsr)
          bsr_upd_nxt = bsr_shift_r;
      end
      default:
        bypass_nxt = bypass_r;
    endcase
  end

  always_ff @(posedge tck)
  begin
    if (!tck_rst_n)
    begin
      id_shift_r  <= '0;
      bypass_r    <= BYPASS_CAPTURE;
      bsr_shift_r <= '0;
      bsr_upd_r   <= '0;
    end
    else
    begin
      id_shift_r  <= id_shift_nxt;
      bypass_r    <= bypass_nxt;
      bsr_shift_r <= bsr_shift_nxt;
      bsr_upd_r   <= bsr_upd_nxt;
    end
  end

  // Serial output changes on the falling edge only while shifting
  always_comb
  begin
    tdo_nxt    = tdo_r;
    tdo_oe_nxt = 1'h0;
    case (state)
      ST_SH_IR:
      begin
        tdo_nxt    = ir_shift_r[0];
        tdo_oe_nxt = 1'h1;
      end
      ST_SH_DR:
      begin
        tdo_oe_nxt = 1'h1;
        if (sel_id)
          tdo_nxt = id_shift_r[0];
        else if (sel_bsr)
          tdo_nxt = bsr_shift_r[0];
        else
          tdo_nxt = bypass_r;
      end
      default:
        tdo_oe_nxt = 1'h0;
    endcase
  end

  always_ff @(negedge tck)
  begin
    if (!tck_rst_n)
    begin
      tdo_r    <= 1'h0;
      tdo_oe_r <= 1'h0;
    end
    else
    begin
      tdo_r    <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign tdo         = tdo_r;
  assign tdo_oe      = tdo_oe_r;
  assign pin_drive   = bsr_upd_r;
  assign pin_test_en = pin_test_en_r;
  assign pin_hiz     = pin_hiz_r;

  ir_after_reset_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_TLR |=> ir_r == INS_IDCODE)
    else $error("instruction not identification after reset state");

  ir_capture_pat_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_CAP_IR |=> ir_shift_r[1:0] == IR_CAPTURE_PAT)
    else $error("capture-IR pattern missing");

  ir_hold_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state != ST_UPD_IR && state != ST_TLR |=> $stable(ir_r))
    else $error("instruction changed outside update-IR");

  id_load_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_CAP_DR && ir_r == INS_IDCODE |=> id_shift_r == ID_CODE)
    else $error("identity code not captured");

  mode_two_word_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_CAP_DR && ir_r == INS_MODE_TWO
    |=> id_shift_r[0] && id_shift_r[ID_W-1:11] == '0 && id_shift_r[10:1] == $past(mtwo_c_r))
    else $error("mode two word wrong");

  mode_pair_word_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_CAP_DR && ir_r == INS_MODE_PAIR
    |=> id_shift_r[0] && id_shift_r[31:29] == 3'h0 && id_shift_r[16:14] == 3'h0
        && id_shift_r[28:17] == $past(mone_c_r) && id_shift_r[12:1] == $past(mzero_c_r)
        && id_shift_r[ID_REPAIR_BIT] == $past(rep_c_r))
    else $error("mode pair word wrong");

  id_shift_in_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_SH_DR && sel_id
    |=> id_shift_r[ID_W-1] == $past(tdi) && id_shift_r[ID_W-2:0] == $past(id_shift_r[ID_W-1:1]))
    else $error("identification register did not shift");

  hiz_force_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    ir_r == INS_HIGHZ |-> pin_hiz_r && !pin_test_en_r && sel_byp)
    else $error("high-impedance not forced");

  extest_enable_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_UPD_IR && ir_shift_r == INS_EXTEST |=> pin_test_en_r && !pin_hiz_r)
    else $error("drivers not enabled by external test");

  drive_stable_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state != ST_UPD_DR |=> $stable(bsr_upd_r))
    else $error("drive latch moved outside update-DR");

  sample_snap_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_CAP_DR && ir_r == INS_SAMPLE |=> bsr_shift_r == $past(pin_s2_r))
    else $error("sample snapshot wrong");

  bypass_cap_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_CAP_DR && ir_r == INS_BYPASS ##1 state == ST_SH_DR |-> bypass_r == 1'h0)
    else $error("bypass bit not cleared at capture");

  // Split in two so the unsettled state before the first reset edge cannot fire them
  tdo_enable_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state == ST_SH_IR || state == ST_SH_DR |-> tdo_oe_r)
    else $error("serial output not enabled while shifting");

  tdo_float_a: assert property (
    @(posedge tck) disable iff (!tck_rst_n)
    state != ST_SH_IR && state != ST_SH_DR |-> !tdo_oe_r)
    else $error("serial output enable outside shift states");

endmodule : jtg_tap_top

//--- tb/jtg_ctrl_model.sv
`timescale 1ns/10ps
module jtg_ctrl_model
  import jtg_pkg::*;
(
  // Test access port toward the device
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // Answer from the device
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  // 8 MHz test clock, far below the ceiling
  localparam realtime HALF = 62.5;
  int oe_miss;
  logic oe_q;

  // Clock stands low between frames, pulled-up lines idle high
  initial
  begin
    tck     = 1'b0;
    tms     = 1'b1;
    tdi     = 1'b1;
    oe_miss = 0;
  end

  // One test clock, inputs changed after the falling edge
  task automatic pulse(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(HALF);
    tck = 1'b1;
    // Released line reads inverted, so a missing enable cannot pass
    q    = tdo_oe ? tdo : ~tdo;
    oe_q = tdo_oe;
    #(HALF);
    tck = 1'b0;
  endtask : pulse

  // Idle clocks in run-test/idle
  task automatic idle(input int n);
    logic q;
    repeat (n) pulse(1'b0, 1'b1, q);
  endtask : idle

  // Five high mode bits, then into run-test/idle
  task automatic reset_tap();
    logic q;
    repeat (5) pulse(1'b1, 1'b1, q);
    pulse(1'b0, 1'b1, q);
  endtask : reset_tap

  // Full scan from idle back to idle; slow adds idle clocks first
  task automatic scan(input logic ir, input int n, input int slow,
                      input logic [BSR_W-1:0] din, output logic [BSR_W-1:0] dout);
    logic q;
    dout = '0;
    idle(slow);
    pulse(1'b1, 1'b1, q);
    if (ir)
      pulse(1'b1, 1'b1, q);
    pulse(1'b0, 1'b1, q);
    pulse(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
      if (oe_q !== 1'b1)
        oe_miss++;
    end
    pulse(1'b1, 1'b1, q); // Code only takes effect at update
    pulse(1'b0, 1'b1, q);
  endtask : scan
endmodule : jtg_ctrl_model

//--- tb/test_jtag_instruction_and_id_logic.sv
`timescale 1ns/10ps
module test_jtag_instruction_and_id_logic
  import jtg_pkg::*;
;
  localparam logic [ID_W-1:0] TB_ID = 32'h6B2E_94C3; // Arbitrary value

  typedef struct packed {
    logic [IR_W-1:0] ins;
    logic [1:0]      sel; // 0 word, 1 bypass, 2 boundary
    logic            ten;
    logic            hiz;
  } jtg_tb_row_t;

  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [MR01_W-1:0] mzero = 12'hA5C;
  logic [MR01_W-1:0] mone = 12'h3E1;
  logic [MTWO_W-1:0] mtwo = 10'h2B7;
  logic              rep_flag = 1'b1;
  logic              tck, tms, tdi, tdo, tdo_oe, pin_test_en, pin_hiz;
  logic [BSR_W-1:0]  pin_in = '0;
  logic [BSR_W-1:0]  pin_drive, din, pins, got, drv_exp;
  logic [ID_W-1:0]   word;
  jtg_tb_row_t       r;
  int                err_total = 0;
  int                cmp_count = 0;

  // Only defined codes; sample preloads before external
  jtg_tb_row_t rows [8] = '{
    '{INS_IDCODE, 2'h0, 1'h0, 1'h0}, '{INS_MODE_PAIR, 2'h0, 1'h0, 1'h0},
    '{INS_MODE_TWO, 2'h0, 1'h0, 1'h0}, '{INS_BYPASS, 2'h1, 1'h0, 1'h0},
    '{INS_HIGHZ, 2'h1, 1'h0, 1'h1}, '{INS_SAMPLE, 2'h2, 1'h0, 1'h0},
    '{INS_EXTEST, 2'h2, 1'h1, 1'h0}, '{INS_CLAMP, 2'h1, 1'h1, 1'h0}};

  always #2 ref_clk = ~ref_clk;

  jtg_tap_top #(.ID_CODE(TB_ID)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .mode_register_zero(mzero), .mode_register_one(mone),
    .mode_register_two(mtwo), .post_package_repair_flag(rep_flag), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_drive(pin_drive),
    .pin_test_en(pin_test_en), .pin_hiz(pin_hiz));

  jtg_ctrl_model ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  task automatic chk(input string nm, input logic [BSR_W-1:0] exp, input logic [BSR_W-1:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [BSR_W-1:0] dr_exp(input logic [1:0] sel, input logic [ID_W-1:0] w,
                                              input logic [BSR_W-1:0] d, input logic [BSR_W-1:0] p);
    case (sel)
      2'h0:    dr_exp = {d[BSR_W-ID_W-1:0], w};
      2'h1:    dr_exp = {d[BSR_W-2:0], BYPASS_CAPTURE};
      default: dr_exp = p;
    endcase
  endfunction : dr_exp

  // Reset long enough for the test clock side to see it
  task automatic do_reset();
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    ctrl.idle(3);
    @(negedge ref_clk);
    rst_n = 1'b1;
    ctrl.idle(4);
    chk("oe_rst", 1'b0, tdo_oe);
    chk("drive_rst", '0, pin_drive);
    chk("ten_rst", 1'b0, pin_test_en);
    chk("hiz_rst", 1'b0, pin_hiz);
    ctrl.scan(1'b0, ID_W, 0, '0, got);
    chk("id_rst", TB_ID, got);
  endtask : do_reset

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // Cuts a hang well past the expected run length
  initial
  begin
    #400us;
    err_total++;
    conclude();
  end

  // Main sequence
  initial
  begin
    drv_exp = '0;
    do_reset();
    ctrl.idle(8);
    for (int i = 0; i < 8; i++)
    begin
      r    = rows[i];
      din  = {5{27'h2B3C5D1}} << i;
      pins = {5{27'h5D1A2B3}} >> i;
      @(negedge ref_clk);
      pin_in = pins; // Held steady long before capture
      ctrl.scan(1'b1, IR_W, i % 2, {{(BSR_W-IR_W){1'b0}}, r.ins}, got);
      chk("ir_capture", {{(BSR_W-2){1'b0}}, IR_CAPTURE_PAT}, got);
      chk("test_en", r.ten, pin_test_en);
      chk("hiz", r.hiz, pin_hiz);
      chk("drive_ir", drv_exp, pin_drive);
      word = (r.ins == INS_MODE_PAIR) ? {3'h0, mone, 3'h0, rep_flag, mzero, 1'h1} :
             (r.ins == INS_MODE_TWO) ? {21'h0, mtwo, 1'h1} : TB_ID;
      ctrl.scan(1'b0, BSR_W, 0, din, got);
      chk("dr_out", dr_exp(r.sel, word, din, pins), got);
      if (r.sel == 2'h2)
        drv_exp = din;
      chk("drive_dr", drv_exp, pin_drive);
      chk("oe_idle", 1'b0, tdo_oe);
    end
    // Mode registers at their extremes, read again after they settle
    @(negedge ref_clk);
    mzero = 12'hFFF;
    mone = 12'h000;
    mtwo = 10'h3FF;
    rep_flag = 1'b0;
    ctrl.idle(8);
    ctrl.scan(1'b1, IR_W, 0, {{(BSR_W-IR_W){1'b0}}, INS_MODE_PAIR}, got);
    ctrl.scan(1'b0, ID_W, 0, '0, got);
    chk("pair_new", {3'h0, mone, 3'h0, rep_flag, mzero, 1'h1}, got);
    ctrl.scan(1'b1, IR_W, 0, {{(BSR_W-IR_W){1'b0}}, INS_MODE_TWO}, got);
    ctrl.scan(1'b0, ID_W, 0, '0, got);
    chk("two_new", {21'h0, mtwo, 1'h1}, got);
    // Clamp, then a reset by mode bits alone
    ctrl.scan(1'b1, IR_W, 0, {{(BSR_W-IR_W){1'b0}}, INS_CLAMP}, got);
    chk("clamp_en", 1'b1, pin_test_en);
    ctrl.reset_tap();
    chk("ten_tlr", 1'b0, pin_test_en);
    ctrl.scan(1'b0, ID_W, 0, '0, got);
    chk("id_tlr", TB_ID, got);
    // External test driving, then a second reset in mid-run
    ctrl.scan(1'b1, IR_W, 0, {{(BSR_W-IR_W){1'b0}}, INS_EXTEST}, got);
    chk("ext_drive", drv_exp, pin_drive);
    do_reset();
    chk("oe_shift", '0, ctrl.oe_miss);
    conclude();
  end
endmodule : test_jtag_instruction_and_id_logic
